// ### hdl/rdmu_top.sv
// Decided for this implementation: the address-and-strobe port and the placing of the registers.
`timescale 1ns/10ps
// Function
// - variable left-clear rotates by low six amount bits
// - left-clear mask: ones from begin to 63
// - right-clear mask: ones from 0 to end
// - immediate left-clear takes amount from instruction
// - record flag updates condition field zero
// - 32-bit implementation raises illegal instruction
// - end 63 gives pure left rotation
// - amount 64-n, begin n: right shift
// - amount zero, begin n: clear top bits
// - begin zero gives full left or right rotation
module rdmu_top
  import rdmu_pkg::*;
(
  input  wire  logic        clk,
  input  wire  logic        rst,
  input  wire  logic        issue_valid,
  input  wire  logic [31:0] instr,
  input  wire  logic [63:0] source_register,
  input  wire  logic [63:0] amount_register,
  input  wire  logic        summary_overflow,
  input  wire  logic        impl_64bit,
  output logic              target_write,
  output logic       [4:0]  target_register,
  output logic       [63:0] target_value,
  output logic              cr0_write,
  output logic       [3:0]  condition_field_zero,
  output logic              illegal_instr,
  output logic              unit_claim,
  input  wire  logic [4:0]  reg_addr,
  input  wire  logic [31:0] reg_wdata,
  input  wire  logic        reg_wr,
  input  wire  logic        reg_rd,
  output logic       [31:0] reg_rdata,
  output logic              irq
);

  rdmu_op_t    dec_op;
  logic [5:0]  dec_amount;
  logic [5:0]  dec_mask_bound;
  logic [4:0]  dec_target;
  logic        dec_record;
  logic        exec_ok;
  logic        exec_bad;
  logic [63:0] alu_result;
  logic [3:0]  cr_bits;

  // decode
  always_comb begin
    dec_op = RDMU_OP_NONE;
    if (issue_valid && instr[RDMU_PRIM_MSB:RDMU_PRIM_LSB] == RDMU_PRIMARY_OPC) begin
      if (instr[RDMU_XO4_MSB:RDMU_XO4_LSB] == RDMU_XO_VAR_LEFT) begin
        dec_op = RDMU_OP_VAR_LEFT;
      end else if (instr[RDMU_XO4_MSB:RDMU_XO4_LSB] == RDMU_XO_VAR_RIGHT) begin
        dec_op = RDMU_OP_VAR_RIGHT;
      end else if (instr[RDMU_XO4_MSB:RDMU_XO3_LSB] == RDMU_XO_IMM_LEFT) begin
        dec_op = RDMU_OP_IMM_LEFT;
      end
    end
    if (dec_op == RDMU_OP_IMM_LEFT) begin
      dec_amount = rdmu_split6(instr[RDMU_SHHI_POS],
                               instr[RDMU_SHLO_MSB:RDMU_SHLO_LSB]);
    end else begin
      dec_amount = amount_register[RDMU_AMT_W-1:0];
    end
    dec_mask_bound = rdmu_split6(instr[RDMU_MSKHI_POS],
                                 instr[RDMU_MSKLO_MSB:RDMU_MSKLO_LSB]);
    dec_target     = instr[RDMU_TGT_MSB:RDMU_TGT_LSB];
    dec_record     = instr[RDMU_REC_POS];
    unit_claim     = (dec_op != RDMU_OP_NONE);
    exec_ok        = unit_claim && impl_64bit;
    exec_bad       = unit_claim && !impl_64bit;
  end

  rdmu_rotmask u_rotmask (
    .op         (dec_op),
    .src_value  (source_register),
    .rot_amount (dec_amount),
    .mask_bound (dec_mask_bound),
    .result     (alu_result)
  );

  always_comb begin
    cr_bits               = 4'h0;
    cr_bits[RDMU_CR_NEG]  = alu_result[RDMU_XLEN-1];
    cr_bits[RDMU_CR_POS]  = !alu_result[RDMU_XLEN-1] && (|alu_result);
    cr_bits[RDMU_CR_ZERO] = ~(|alu_result);
    cr_bits[RDMU_CR_SO]   = summary_overflow;
  end

  // result stage
  logic        tgt_wr_ff;
  logic        nxt_tgt_wr;
  logic [4:0]  tgt_idx_ff;
  logic [4:0]  nxt_tgt_idx;
  logic [63:0] tgt_val_ff;
  logic [63:0] nxt_tgt_val;
  logic        cr_wr_ff;
  logic        nxt_cr_wr;
  logic [3:0]  cr_val_ff;
  logic [3:0]  nxt_cr_val;
  logic        illegal_ff;
  logic        nxt_illegal;

  always_comb begin
    nxt_tgt_wr  = exec_ok;
    nxt_tgt_idx = tgt_idx_ff;
    nxt_tgt_val = tgt_val_ff;
    nxt_cr_wr   = exec_ok && dec_record;
    nxt_cr_val  = cr_val_ff;
    nxt_illegal = exec_bad;
    if (exec_ok) begin
      nxt_tgt_idx = dec_target;
      nxt_tgt_val = alu_result;
      if (dec_record) begin
        nxt_cr_val = cr_bits;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      tgt_wr_ff  <= 1'b0;
      tgt_idx_ff <= 5'h00;
      tgt_val_ff <= RDMU_RESULT_RST;
      cr_wr_ff   <= 1'b0;
      cr_val_ff  <= 4'h0;
      illegal_ff <= 1'b0;
    end else begin
      tgt_wr_ff  <= nxt_tgt_wr;
      tgt_idx_ff <= nxt_tgt_idx;
      tgt_val_ff <= nxt_tgt_val;
      cr_wr_ff   <= nxt_cr_wr;
      cr_val_ff  <= nxt_cr_val;
      illegal_ff <= nxt_illegal;
    end
  end

  assign target_write         = tgt_wr_ff;
  assign target_register      = tgt_idx_ff;
  assign target_value         = tgt_val_ff;
  assign cr0_write            = cr_wr_ff;
  assign condition_field_zero = cr_val_ff;
  assign illegal_instr        = illegal_ff;

  // status, mask, counter and read port
  logic [2:0]  status_ff;
  logic [2:0]  nxt_status;
  logic [2:0]  irq_mask_ff;
  logic [2:0]  nxt_irq_mask;
  logic [15:0] count_ff;
  logic [15:0] nxt_count;
  logic [31:0] rdata_ff;
  logic [31:0] nxt_rdata;
  logic [2:0]  events;
  logic [2:0]  clr_bits;

  always_comb begin
    events                   = 3'h0;
    events[RDMU_EVT_DONE]    = exec_ok;
    events[RDMU_EVT_ILLEGAL] = exec_bad;
    events[RDMU_EVT_RECORD]  = exec_ok && dec_record;
    clr_bits                 = 3'h0;
    if (reg_wr && reg_addr == RDMU_REG_STATUS) begin
      clr_bits = reg_wdata[RDMU_EVT_W-1:0];
    end
    // a new event wins over a same-cycle clear
    nxt_status   = (status_ff & ~clr_bits) | events;
    nxt_irq_mask = irq_mask_ff;
    if (reg_wr && reg_addr == RDMU_REG_MASK) begin
      nxt_irq_mask = reg_wdata[RDMU_EVT_W-1:0];
    end
    nxt_count = count_ff;
    if (exec_ok) begin
      nxt_count = count_ff + 16'h0001;
    end
    nxt_rdata = RDMU_RDATA_RST;
    if (reg_rd) begin
      unique case (reg_addr)
        RDMU_REG_STATUS: nxt_rdata = {29'h00000000, status_ff};
        RDMU_REG_MASK:   nxt_rdata = {29'h00000000, irq_mask_ff};
        RDMU_REG_COUNT:  nxt_rdata = {16'h0000, count_ff};
        RDMU_REG_RES_LO: nxt_rdata = tgt_val_ff[31:0];
        RDMU_REG_RES_HI: nxt_rdata = tgt_val_ff[63:32];
        default:         nxt_rdata = RDMU_RDATA_RST;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      status_ff   <= RDMU_EVT_RST;
      irq_mask_ff <= RDMU_EVT_RST;
      count_ff    <= RDMU_COUNT_RST;
      rdata_ff    <= RDMU_RDATA_RST;
    end else begin
      status_ff   <= nxt_status;
      irq_mask_ff <= nxt_irq_mask;
      count_ff    <= nxt_count;
      rdata_ff    <= nxt_rdata;
    end
  end

  assign reg_rdata = rdata_ff;
  assign irq       = |(status_ff & irq_mask_ff);

endmodule

// ### hdl/rdmu_pkg.sv
package rdmu_pkg;

  localparam int          RDMU_XLEN          = 64;
  localparam int          RDMU_AMT_W         = 6;

  // instruction field positions, little-endian index (big-endian bit b is index 31-b)
  localparam int          RDMU_PRIM_MSB      = 31;
  localparam int          RDMU_PRIM_LSB      = 26;
  localparam int          RDMU_SRC_MSB       = 25;
  localparam int          RDMU_SRC_LSB       = 21;
  localparam int          RDMU_TGT_MSB       = 20;
  localparam int          RDMU_TGT_LSB       = 16;
  localparam int          RDMU_SHLO_MSB      = 15;
  localparam int          RDMU_SHLO_LSB      = 11;
  localparam int          RDMU_MSKLO_MSB     = 10;
  localparam int          RDMU_MSKLO_LSB     = 6;
  localparam int          RDMU_MSKHI_POS     = 5;
  localparam int          RDMU_XO4_MSB       = 4;
  localparam int          RDMU_XO4_LSB       = 1;
  localparam int          RDMU_XO3_LSB       = 2;
  localparam int          RDMU_SHHI_POS      = 1;
  localparam int          RDMU_REC_POS       = 0;

  localparam logic [5:0]  RDMU_PRIMARY_OPC   = 6'h1E;
  localparam logic [3:0]  RDMU_XO_VAR_LEFT   = 4'h8;
  localparam logic [3:0]  RDMU_XO_VAR_RIGHT  = 4'h9;
  localparam logic [2:0]  RDMU_XO_IMM_LEFT   = 3'h0;

  // register port, byte addresses
  localparam int          RDMU_ADDR_W        = 5;
  localparam logic [4:0]  RDMU_REG_STATUS    = 5'h00;
  localparam logic [4:0]  RDMU_REG_MASK      = 5'h04;
  localparam logic [4:0]  RDMU_REG_COUNT     = 5'h08;
  localparam logic [4:0]  RDMU_REG_RES_LO    = 5'h0C;
  localparam logic [4:0]  RDMU_REG_RES_HI    = 5'h10;

  localparam int          RDMU_EVT_W         = 3;
  localparam int          RDMU_EVT_DONE      = 0;
  localparam int          RDMU_EVT_ILLEGAL   = 1;
  localparam int          RDMU_EVT_RECORD    = 2;

  // condition field zero layout
  localparam int          RDMU_CR_NEG        = 3;
  localparam int          RDMU_CR_POS        = 2;
  localparam int          RDMU_CR_ZERO       = 1;
  localparam int          RDMU_CR_SO         = 0;

  localparam logic [2:0]  RDMU_EVT_RST       = 3'h0;
  localparam logic [15:0] RDMU_COUNT_RST     = 16'h0000;
  localparam logic [63:0] RDMU_RESULT_RST    = 64'h0000000000000000;
  localparam logic [31:0] RDMU_RDATA_RST     = 32'h00000000;

  typedef enum logic [1:0] {
    RDMU_OP_NONE      = 2'b00,
    RDMU_OP_VAR_LEFT  = 2'b01,
    RDMU_OP_VAR_RIGHT = 2'b11,
    RDMU_OP_IMM_LEFT  = 2'b10
  } rdmu_op_t;

  // six-bit field whose top bit sits apart from the low five
  function automatic logic [5:0] rdmu_split6(input logic hi, input logic [4:0] lo);
    rdmu_split6 = {hi, lo};
  endfunction

endpackage

// ### hdl/rdmu_rotmask.sv
`timescale 1ns/10ps
module rdmu_rotmask
  import rdmu_pkg::*;
(
  input  wire rdmu_op_t    op,
  input  wire logic [63:0] src_value,
  input  wire logic [5:0]  rot_amount,
  input  wire logic [5:0]  mask_bound,
  output logic      [63:0] result
);

  logic [63:0] rotated;
  logic [63:0] mask;
  logic [6:0]  back_amount;

  always_comb begin
    back_amount = 7'h40 - {1'b0, rot_amount};
    // left rotate; a zero amount leaves the right shift at 64, which yields zero
    rotated     = (src_value << rot_amount) | (src_value >> back_amount);
    unique case (op)
      RDMU_OP_VAR_LEFT, RDMU_OP_IMM_LEFT: begin
        mask = {RDMU_XLEN{1'b1}} >> mask_bound;
      end
      RDMU_OP_VAR_RIGHT: begin
        mask = {RDMU_XLEN{1'b1}} << (6'h3F - mask_bound);
      end
      RDMU_OP_NONE: begin
        mask = 64'h0000000000000000;
      end
    endcase
    result = rotated & mask;
  end

endmodule

// ### sim/rdmu_top_checker.sv
`timescale 1ns/10ps
module rdmu_top_checker
  import rdmu_pkg::*;
(
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        issue_valid,
  input wire logic [31:0] instr,
  input wire logic        impl_64bit,
  input wire logic        summary_overflow,
  input wire logic        target_write,
  input wire logic [63:0] target_value,
  input wire logic        cr0_write,
  input wire logic [3:0]  condition_field_zero,
  input wire logic        illegal_instr,
  input wire logic        unit_claim,
  input wire logic        reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic        irq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  wire logic exe = issue_valid && unit_claim && impl_64bit;
  a_exec_latency: assert property (exe |=> target_write && !illegal_instr)
    else $error("claimed op gave no write one cycle later");
  a_illegal_refuse: assert property (issue_valid && unit_claim && !impl_64bit
    |=> illegal_instr && !target_write && !cr0_write) else $error("illegal op not refused");
  a_idle_quiet: assert property (!(issue_valid && unit_claim)
    |=> !target_write && !illegal_instr) else $error("pulse without claimed op");
  a_claim_decode: assert property (unit_claim == (issue_valid
    && instr[31:26] == RDMU_PRIMARY_OPC && (instr[4:1] == RDMU_XO_VAR_LEFT
    || instr[4:1] == RDMU_XO_VAR_RIGHT || instr[4:2] == RDMU_XO_IMM_LEFT)))
    else $error("claim does not follow opcode");
  a_record_write: assert property (exe |=> cr0_write == $past(instr[0]))
    else $error("cr write does not follow record flag");
  // the reset edge clears the field without a record pulse
  a_cr_hold: assert property (!cr0_write && !$past(rst)
    |-> $stable(condition_field_zero)) else $error("condition field changed without record");
  a_cr_flags: assert property (cr0_write |->
    condition_field_zero[1] == (target_value == 64'h0)
    && condition_field_zero[2] == (!target_value[63] && target_value != 64'h0)
    && condition_field_zero[3] == target_value[63]) else $error("cr flags wrong");
  a_so_copy: assert property (exe && instr[0]
    |=> condition_field_zero[0] == $past(summary_overflow)) else $error("so not copied");
  a_read_idle: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
    else $error("read data outside read slot");
  c_record: cover property (exe && instr[0]);
  c_illegal: cover property (illegal_instr);
  c_irq: cover property (irq);
  c_back_to_back: cover property (target_write ##1 target_write);
endmodule

bind rdmu_top rdmu_top_checker chk_u (.clk(clk), .rst(rst), .issue_valid(issue_valid),
  .instr(instr), .impl_64bit(impl_64bit), .summary_overflow(summary_overflow),
  .target_write(target_write), .target_value(target_value), .cr0_write(cr0_write),
  .condition_field_zero(condition_field_zero), .illegal_instr(illegal_instr),
  .unit_claim(unit_claim), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq));

// ### sim/rdmu_core_model.sv
`timescale 1ns/10ps
module rdmu_core_model
  import rdmu_pkg::*;
(
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        go,
  input wire logic [1:0]  k,
  input wire logic [5:0]  amt,
  input wire logic [5:0]  bnd,
  input wire logic        rec,
  output logic            issue_valid,
  output logic     [31:0] instr,
  output logic     [63:0] source_register,
  output logic     [63:0] amount_register
);
  initial begin
    issue_valid = 1'b0;
    instr = 32'h0;
    source_register = 64'h0;
    amount_register = 64'h0;
  end
  always @(posedge clk) begin
    if (go && !rst) begin
      issue_valid <= 1'b1;
      instr <= {RDMU_PRIMARY_OPC, 5'h03, 5'h07, k[1] ? amt[4:0] : 5'h04, bnd[4:0], bnd[5],
                k[1] ? {RDMU_XO_IMM_LEFT, amt[5]} : (k[0] ? RDMU_XO_VAR_RIGHT : RDMU_XO_VAR_LEFT), rec};
      source_register <= 64'h8123456789ABCDEF;
      amount_register <= {{29{2'b10}}, amt};
    end else begin
      // released operands wander so stale values never match
      issue_valid <= 1'b0;
      instr <= ~instr;
      source_register <= ~source_register;
      amount_register <= ~amount_register;
    end
  end
endmodule

// ### sim/rdmu_top_tb.sv
`timescale 1ns/10ps
module rdmu_top_tb
  import rdmu_pkg::*;
;
  typedef struct packed {
    logic [1:0] k; logic [5:0] amt; logic [5:0] bnd; logic rec; logic [63:0] exp;
  } rdmu_row_t;
  logic clk, rst, go, rec, so, impl, reg_wr, reg_rd, iv, tw, crw, ill, claim, irq;
  logic [1:0] k;
  logic [5:0] amt, bnd;
  logic [4:0] reg_addr, tgt;
  logic [31:0] reg_wdata, instr, reg_rdata;
  logic [63:0] src, amr, tv;
  logic [3:0] cr, cr_exp;
  int error_cnt, n_tests;
  rdmu_row_t rows [8];

  rdmu_core_model model_u (.clk(clk), .rst(rst), .go(go), .k(k), .amt(amt), .bnd(bnd), .rec(rec),
    .issue_valid(iv), .instr(instr), .source_register(src), .amount_register(amr));
  rdmu_top dut_u (.clk(clk), .rst(rst), .issue_valid(iv), .instr(instr), .source_register(src),
    .amount_register(amr), .summary_overflow(so), .impl_64bit(impl), .target_write(tw),
    .target_register(tgt), .target_value(tv), .cr0_write(crw), .condition_field_zero(cr),
    .illegal_instr(ill), .unit_claim(claim), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq));

  task automatic chk_val(input logic [63:0] g, input logic [63:0] e);
    n_tests++;
    if (g !== e) begin
      error_cnt++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic chk_flag(input logic [7:0] g, input logic [7:0] e);
    chk_val({56'h0, g}, {56'h0, e});
  endtask
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr <= a; reg_wdata <= d; reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [4:0] a, input logic [31:0] e);
    @(posedge clk);
    reg_addr <= a; reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 chk_val({32'h0, reg_rdata}, {32'h0, e});
  endtask
  task automatic put(input rdmu_row_t r);
    {k, amt, bnd, rec} <= {r.k, r.amt, r.bnd, r.rec};
  endtask
  task automatic run(input rdmu_row_t r);
    @(posedge clk);
    put(r); go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    @(posedge clk);
    #1;
  endtask
  task automatic close_out;
    $display("tests %0d errors %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  initial begin
    repeat (5000) @(posedge clk);
    error_cnt++;
    close_out();
  end
  initial begin
    {rst, go, rec, so, impl, reg_wr, reg_rd} = 7'h44;
    {k, amt, bnd, reg_addr, reg_wdata} = 0;
    rows = '{'{2'h0, 6'h04, 6'h00, 1'b0, 64'h123456789ABCDEF8},
             '{2'h0, 6'h3C, 6'h00, 1'b0, 64'hF8123456789ABCDE},
             '{2'h0, 6'h08, 6'h20, 1'b0, 64'h00000000ABCDEF81},
             '{2'h1, 6'h04, 6'h3F, 1'b1, 64'h123456789ABCDEF8},
             '{2'h1, 6'h00, 6'h00, 1'b1, 64'h8000000000000000},
             '{2'h2, 6'h38, 6'h08, 1'b1, 64'h008123456789ABCD},
             '{2'h2, 6'h00, 6'h0C, 1'b0, 64'h0003456789ABCDEF},
             '{2'h0, 6'h04, 6'h3F, 1'b1, 64'h0000000000000000}};
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    cr_exp = 4'h0;
    for (int i = 0; i < 8; i++) begin
      so <= i[0];
      run(rows[i]);
      chk_val(tv, rows[i].exp);
      chk_flag({3'h0, tgt}, 8'h07);
      if (rows[i].rec) cr_exp = {rows[i].exp[63], !rows[i].exp[63] && rows[i].exp != 0,
                                 rows[i].exp == 0, i[0]};
      chk_flag({2'h0, tw, crw, cr}, {2'h0, 1'b1, rows[i].rec, cr_exp});
      $display("row %0d done", i);
    end
    @(posedge clk);
    put(rows[0]); go <= 1'b1;
    @(posedge clk);
    put(rows[6]);
    @(posedge clk);
    go <= 1'b0;
    #1 chk_val(tv, rows[0].exp);
    @(posedge clk);
    #1 chk_val(tv, rows[6].exp);
    $display("back to back done");
    impl <= 1'b0;
    run(rows[1]);
    chk_flag({5'h00, ill, tw, crw}, 8'h04);
    chk_val(tv, rows[6].exp);
    impl <= 1'b1;
    $display("illegal done");
    rd(RDMU_REG_COUNT, 32'h0000000A);
    wr(RDMU_REG_COUNT, 32'h00000055);
    rd(RDMU_REG_COUNT, 32'h0000000A);
    rd(RDMU_REG_RES_LO, 32'h89ABCDEF);
    rd(RDMU_REG_RES_HI, 32'h00034567);
    rd(5'h14, 32'h0);
    rd(RDMU_REG_STATUS, 32'h00000007);
    #1 chk_flag({7'h00, irq}, 8'h00);
    wr(RDMU_REG_MASK, 32'h00000002);
    #1 chk_flag({7'h00, irq}, 8'h01);
    wr(RDMU_REG_STATUS, 32'h00000002);
    #1 chk_flag({7'h00, irq}, 8'h00);
    rd(RDMU_REG_STATUS, 32'h00000005);
    $display("registers done");
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    #1 chk_val(tv, 64'h0);
    chk_flag({3'h0, cr, irq}, 8'h00);
    rd(RDMU_REG_COUNT, 32'h0);
    $display("reset done");
    close_out();
  end
endmodule
